//--- mebp_pkg.sv
// constants and types shared by the external bus pin block
`default_nettype none
package mebp_pkg;
   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int MEBP_ADDR_W = 16;             // address pins
   localparam int MEBP_DATA_W = 8;              // bidirectional data pins
   // ----------------------------------------------------------------
   // mode strap patterns {high, low}
   // ----------------------------------------------------------------
   localparam logic [1:0] MEBP_MODE_EXP_NOROM = 2'h1; // expanded, rom off
   localparam logic [1:0] MEBP_MODE_EXP_ROM   = 2'h2; // expanded, rom on
   localparam logic [1:0] MEBP_MODE_SINGLE    = 2'h3; // single chip
   // ----------------------------------------------------------------
   // address map and reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] MEBP_ONCHIP_TOP = 16'h7fff; // last rom address
   localparam logic [15:0] MEBP_ADDR_RST   = 16'h0000; // idle address
   localparam logic [7:0]  MEBP_DATA_RST   = 8'h00;    // data reset value
   localparam logic [7:0]  MEBP_ONCHIP_RD  = 8'h00;    // on-chip read value
   localparam logic [1:0]  MEBP_BUF_DEPTH  = 2'h2;     // buffer entries
   // ----------------------------------------------------------------
   // bus cycle states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      MEBP_ST_IDLE,                             // no access on the pins
      MEBP_ST_T1,                               // address out, strobe low
      MEBP_ST_T2,                               // read or write strobe low
      MEBP_ST_WAIT,                             // stretched by wait input
      MEBP_ST_T3                                // last state, data taken
   } mebp_state_t;
endpackage : mebp_pkg
`default_nettype wire

//--- mebp_stream_if.sv
// valid/ready byte stream between the bus block and its buffer
`default_nettype none
interface mebp_stream_if;
   import mebp_pkg::*;
   logic                   valid;               // word offered
   logic                   ready;               // word can be taken
   logic [MEBP_DATA_W-1:0] data;                // the word
   modport src (output valid, output data, input  ready);
   modport snk (input  valid, input  data, output ready);
endinterface : mebp_stream_if
`default_nettype wire

//--- mebp_buf2.sv
// two-entry buffer for read data, stalls the bus when full
`default_nettype none
module mebp_buf2
   import mebp_pkg::*;
(
   input  wire logic   sys_clk_i,               // system clock
   input  wire logic   sys_rst_i,               // async reset, high
   mebp_stream_if.snk  in_s,                    // filled by the bus logic
   mebp_stream_if.src  out_s                    // drained by the user
);
   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [MEBP_DATA_W-1:0] slot0, next_slot0;  // head, read from a flop
   logic [MEBP_DATA_W-1:0] slot1, next_slot1;  // second entry
   logic [1:0]             count, next_count;  // entries held
   logic                   push, pop;          // handshakes this cycle

   assign in_s.ready  = (count != MEBP_BUF_DEPTH); // honest full
   assign out_s.valid = (count != 2'h0);            // honest empty
   assign out_s.data  = slot0;
   assign push        = in_s.valid && in_s.ready;
   assign pop         = out_s.valid && out_s.ready;

   // next contents: head shifts on pop, push lands behind the last
   always_comb begin
      next_slot0 = slot0;
      next_slot1 = slot1;
      next_count = count;
      if (pop) begin
         next_slot0 = slot1;
      end
      if (push) begin
         if (count == 2'h0 || (count == 2'h1 && pop)) begin
            next_slot0 = in_s.data;
         end else begin
            next_slot1 = in_s.data;
         end
      end
      next_count = count + {1'b0, push} - {1'b0, pop};
   end

   // register only
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         slot0 <= MEBP_DATA_RST;
         slot1 <= MEBP_DATA_RST;
         count <= 2'h0;
      end else begin
         slot0 <= next_slot0;
         slot1 <= next_slot1;
         count <= next_count;
      end
   end
endmodule : mebp_buf2
`default_nettype wire

//--- mebp_bus.sv
// external bus pin logic: strobes, address, data, wait, mode, standby
// Behaviour
// - address strobe low while address valid
// - read strobe low on off-chip reads
// - write strobe low on off-chip writes
// - wait input stretches only off-chip cycles
// - eight-bit data pins, driven on writes
// - address pins are outputs only
// - straps pick expanded or single-chip mode
// - low reset input idles the bus and reloads the mode straps; the read buffer keeps its bytes
// - low standby input enters power-down
// - system clock driven out on pin
`default_nettype none
module mebp_bus
   import mebp_pkg::*;
(
   input  wire logic                   sys_clk_i,
   input  wire logic                   sys_rst_i,
   input  wire logic                   chip_reset_in_n_i,
   input  wire logic                   power_down_request_n_i,
   input  wire logic                   mode_strap_high_i,
   input  wire logic                   mode_strap_low_i,
   input  wire logic                   req_valid_i,
   output logic                        req_ready_o,
   input  wire logic                   req_write_i,
   input  wire logic [MEBP_ADDR_W-1:0] req_addr_i,
   input  wire logic [MEBP_DATA_W-1:0] req_wdata_i,
   output logic                        rd_valid_o,
   input  wire logic                   rd_ready_i,
   output logic      [MEBP_DATA_W-1:0] rd_data_o,
   output logic      [MEBP_ADDR_W-1:0] addr_o,
   output logic                        addr_valid_strobe_n_o,
   output logic                        rd_n_o,
   output logic                        wr_n_o,
   input  wire logic                   wait_i,
   input  wire logic [MEBP_DATA_W-1:0] data_i,
   output logic      [MEBP_DATA_W-1:0] data_o,
   output logic                        data_oe_o,
   output logic      [1:0]             mode_o,
   output logic                        standby_o,
   output logic                        sys_clk_out_o
);
   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   mebp_state_t            state, next_state;  // bus cycle sequencer
   logic [MEBP_ADDR_W-1:0] cur_addr, next_cur_addr;   // latched address
   logic [MEBP_DATA_W-1:0] cur_wdata, next_cur_wdata; // latched write data
   logic                   cur_write, next_cur_write; // cycle direction
   logic [1:0]             mode, next_mode;    // decoded strap pattern
   logic                   pdown, next_pdown;  // power-down state
   logic                   as_n, next_as_n;    // pin registers
   logic                   rd_n, next_rd_n;
   logic                   wr_n, next_wr_n;
   logic                   oe, next_oe;
   logic [MEBP_ADDR_W-1:0] addr_q, next_addr_q;
   logic [MEBP_DATA_W-1:0] dout, next_dout;
   logic                   active;             // neither reset nor standby
   logic                   offchip;            // request goes to the pins
   logic                   accept;             // request taken this cycle

   mebp_stream_if push_s ();                   // bus logic into buffer
   mebp_stream_if pop_s ();                    // buffer out to the user

   // ----------------------------------------------------------------
   // clock out and mode decode
   // ----------------------------------------------------------------
   // forwarded straight so external parts share our edges
   assign sys_clk_out_o = sys_clk_i;
   assign active = chip_reset_in_n_i && power_down_request_n_i;

   // off-chip decision: mode 1 all, mode 2 above on-chip rom, mode 3 none
   always_comb begin
      case (mode)
         MEBP_MODE_EXP_NOROM: offchip = 1'b1;
         MEBP_MODE_EXP_ROM:   offchip = (req_addr_i > MEBP_ONCHIP_TOP);
         default:             offchip = 1'b0;  // single chip or bad strap
      endcase
   end

   // accept only when a read result is sure to find buffer room
   assign req_ready_o = active && (state == MEBP_ST_IDLE) && push_s.ready;
   assign accept      = req_valid_i && req_ready_o;

   // ----------------------------------------------------------------
   // sequencer and pin next values
   // ----------------------------------------------------------------
   always_comb begin
      next_state     = state;
      next_cur_addr  = cur_addr;
      next_cur_wdata = cur_wdata;
      next_cur_write = cur_write;
      next_mode      = mode;
      next_pdown     = !power_down_request_n_i;
      // straps follow the pins while reset is held, freeze on release
      if (!chip_reset_in_n_i) begin
         next_mode = {mode_strap_high_i, mode_strap_low_i};
      end
      case (state)
         MEBP_ST_IDLE: begin
            if (accept && offchip) begin
               next_state     = MEBP_ST_T1;
               next_cur_addr  = req_addr_i;
               next_cur_wdata = req_wdata_i;
               next_cur_write = req_write_i;
            end
         end
         MEBP_ST_T1:   next_state = MEBP_ST_T2;
         MEBP_ST_T2: begin
            // wait honoured only because this is an off-chip cycle
            next_state = wait_i ? MEBP_ST_WAIT : MEBP_ST_T3;
         end
         MEBP_ST_WAIT: begin
            next_state = wait_i ? MEBP_ST_WAIT : MEBP_ST_T3;
         end
         MEBP_ST_T3:   next_state = MEBP_ST_IDLE;
         default:      next_state = MEBP_ST_IDLE;
      endcase
      // reset input or standby abandons any cycle on the pins
      if (!active) begin
         next_state = MEBP_ST_IDLE;
      end
   end

   // pins follow the next state so they switch with it, glitch free
   always_comb begin
      next_as_n   = 1'b1;
      next_rd_n   = 1'b1;
      next_wr_n   = 1'b1;
      next_oe     = 1'b0;
      next_addr_q = addr_q;
      next_dout   = dout;
      case (next_state)
         MEBP_ST_IDLE: begin
            next_addr_q = MEBP_ADDR_RST;   // both strobes high
         end
         MEBP_ST_T1: begin
            next_as_n   = 1'b0;
            next_addr_q = next_cur_addr;
            next_dout   = next_cur_wdata;
         end
         default: begin                    // T2, wait, T3
            next_as_n = 1'b0;
            next_rd_n = cur_write;
            next_wr_n = !cur_write;
            next_oe   = cur_write;
         end
      endcase
   end

   // read data: pins at end of T3, on-chip reads give a fixed value
   assign push_s.valid = active && ((state == MEBP_ST_T3 && !cur_write)
                         || (accept && !offchip && !req_write_i));
   assign push_s.data  = (state == MEBP_ST_T3) ? data_i : MEBP_ONCHIP_RD;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state     <= MEBP_ST_IDLE;
         cur_addr  <= MEBP_ADDR_RST;
         cur_wdata <= MEBP_DATA_RST;
         cur_write <= 1'b0;
         mode      <= MEBP_MODE_SINGLE;
         pdown     <= 1'b0;
         as_n      <= 1'b1;
         rd_n      <= 1'b1;
         wr_n      <= 1'b1;
         oe        <= 1'b0;
         addr_q    <= MEBP_ADDR_RST;
         dout      <= MEBP_DATA_RST;
      end else begin
         state     <= next_state;
         cur_addr  <= next_cur_addr;
         cur_wdata <= next_cur_wdata;
         cur_write <= next_cur_write;
         mode      <= next_mode;
         pdown     <= next_pdown;
         as_n      <= next_as_n;
         rd_n      <= next_rd_n;
         wr_n      <= next_wr_n;
         oe        <= next_oe;
         addr_q    <= next_addr_q;
         dout      <= next_dout;
      end
   end

   // ----------------------------------------------------------------
   // read buffer and outputs
   // ----------------------------------------------------------------
   mebp_buf2 u_buf (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .in_s      (push_s),
      .out_s     (pop_s)
   );
   assign pop_s.ready           = rd_ready_i;
   assign rd_valid_o            = pop_s.valid;
   assign rd_data_o             = pop_s.data;
   assign addr_o                = addr_q;
   assign addr_valid_strobe_n_o = as_n;
   assign rd_n_o                = rd_n;
   assign wr_n_o                = wr_n;
   assign data_o                = dout;
   assign data_oe_o             = oe;
   assign mode_o                = mode;
   assign standby_o             = pdown;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_strobe_under_as;
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      (!rd_n_o || !wr_n_o) |-> !addr_valid_strobe_n_o;
   endproperty
   a_strobe_under_as: assert property (p_strobe_under_as)
      else $error("read or write strobe without address strobe");

   property p_read_seq;
      @(posedge sys_clk_i) disable iff (sys_rst_i || !active)
      (accept && offchip && !req_write_i) |=>
         !addr_valid_strobe_n_o && rd_n_o ##1 !rd_n_o && wr_n_o;
   endproperty
   a_read_seq: assert property (p_read_seq)
      else $error("read strobe not low two cycles after accept");

   property p_write_seq;
      @(posedge sys_clk_i) disable iff (sys_rst_i || !active)
      (accept && offchip && req_write_i) |=>
         !addr_valid_strobe_n_o && wr_n_o ##1 !wr_n_o && rd_n_o;
   endproperty
   a_write_seq: assert property (p_write_seq)
      else $error("write strobe not low two cycles after accept");

   property p_wait_entry;
      @(posedge sys_clk_i) disable iff (sys_rst_i || !active)
      (state == MEBP_ST_T2 && wait_i && chip_reset_in_n_i) |=>
         (state == MEBP_ST_WAIT || !active);
   endproperty
   a_wait_entry: assert property (p_wait_entry)
      else $error("wait input ignored in an off-chip cycle");

   property p_drive_on_write;
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      data_oe_o |-> (!wr_n_o && rd_n_o);
   endproperty
   a_drive_on_write: assert property (p_drive_on_write)
      else $error("data pins driven outside a write");

   property p_addr_stable;
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      (!addr_valid_strobe_n_o && !$past(addr_valid_strobe_n_o)) |->
         $stable(addr_o);
   endproperty
   a_addr_stable: assert property (p_addr_stable)
      else $error("address moved while address strobe low");

   property p_single_quiet;
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      (mode == MEBP_MODE_SINGLE && state == MEBP_ST_IDLE) |=>
         addr_valid_strobe_n_o;
   endproperty
   a_single_quiet: assert property (p_single_quiet)
      else $error("bus cycle started in single-chip mode");

   property p_reset_idle;
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      !chip_reset_in_n_i |=>
         (state == MEBP_ST_IDLE && rd_n_o && wr_n_o && !data_oe_o);
   endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("reset input did not idle the bus");

   property p_standby;
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      !power_down_request_n_i |=> (standby_o && addr_valid_strobe_n_o);
   endproperty
   a_standby: assert property (p_standby)
      else $error("standby input did not enter power-down");

   property p_no_both;
      @(posedge sys_clk_i) disable iff (sys_rst_i)
      !(!rd_n_o && !wr_n_o) &&
         (state != MEBP_ST_IDLE || (rd_n_o && wr_n_o));
   endproperty
   a_no_both: assert property (p_no_both)
      else $error("strobes overlap or active while idle");
endmodule : mebp_bus
`default_nettype wire

//--- mebp_mem_model.sv
// behavioural external memory sitting on the device's bus pins
`default_nettype none
module mebp_mem_model
   import mebp_pkg::*;
(
   input  wire logic                   clk_i,        // system clock
   input  wire logic [MEBP_ADDR_W-1:0] addr_i,       // address pins
   input  wire logic                   rd_n_i,       // read strobe
   input  wire logic                   wr_n_i,       // write strobe
   input  wire logic [MEBP_DATA_W-1:0] wdata_i,      // device data out
   input  wire logic                   oe_i,         // device driving
   input  wire logic [3:0]             nwait_i,      // wait states wanted
   input  wire logic                   force_wait_i, // hold wait high
   output logic      [MEBP_DATA_W-1:0] rdata_o,      // data to device
   output logic                        wait_o        // wait request
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:65535];                  // byte storage
   logic [7:0] last = 8'h00;                   // last byte on the lines
   logic [3:0] cnt  = 4'h0;                    // strobe-low cycles
   // no pull-up: released lines toggle so a stale byte is never seen
   assign rdata_o = !rd_n_i ? mem[addr_i] : ~last;
   // stretch each strobed cycle by nwait_i states
   assign wait_o = force_wait_i |
                   ((!rd_n_i | !wr_n_i) & (cnt < nwait_i));
   // strobe counter, line history and write capture
   always @(posedge clk_i) begin
      cnt  <= (!rd_n_i | !wr_n_i) ? cnt + 4'h1 : 4'h0;
      last <= rdata_o;
      if (!wr_n_i && oe_i) begin
         mem[addr_i] <= wdata_i;
      end
   end
endmodule : mebp_mem_model
`default_nettype wire

//--- mebp_bus_tb.sv
// self-checking bench for the external bus pin block
`default_nettype none
module mebp_bus_tb
   import mebp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // -------------------------------
   // signals
   // -------------------------------
   logic sys_clk = 1'b0, sys_rst, chip_rst_n, pd_n, strap_h, strap_l;
   logic req_valid, req_ready, req_write, rd_valid, rd_ready, as_n;
   logic rd_n, wr_n, wait_l, oe, standby, clk_out, force_wait;
   logic [3:0]             nwait;              // partner wait states
   logic [1:0]             mode;
   logic [MEBP_ADDR_W-1:0] req_addr, addr, cur_addr;
   logic [MEBP_DATA_W-1:0] req_wdata, rd_data, din, dout, cur_wdata;
   logic [7:0]             lfsr = 8'h50;       // random source
   logic [7:0]             ref_mem [int];      // expected external bytes
   logic [7:0]             exp_q [$];          // expected read bytes
   logic [15:0]            adr [6];            // addresses used
   int   errors, total_checks, as_cnt, rd_cnt, wr_cnt, i;
   bit   mon_en, cur_wr, cur_on;               // monitor context
   always #4 sys_clk = ~sys_clk;               // 125 MHz
   mebp_bus mebp_bus_inst (
      .sys_clk_i(sys_clk), .sys_rst_i(sys_rst),
      .chip_reset_in_n_i(chip_rst_n), .power_down_request_n_i(pd_n),
      .mode_strap_high_i(strap_h), .mode_strap_low_i(strap_l),
      .req_valid_i(req_valid), .req_ready_o(req_ready),
      .req_write_i(req_write), .req_addr_i(req_addr),
      .req_wdata_i(req_wdata), .rd_valid_o(rd_valid),
      .rd_ready_i(rd_ready), .rd_data_o(rd_data), .addr_o(addr),
      .addr_valid_strobe_n_o(as_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
      .wait_i(wait_l), .data_i(din), .data_o(dout), .data_oe_o(oe),
      .mode_o(mode), .standby_o(standby), .sys_clk_out_o(clk_out));
   mebp_mem_model mebp_mem_model_inst (
      .clk_i(sys_clk), .addr_i(addr), .rd_n_i(rd_n), .wr_n_i(wr_n),
      .wdata_i(dout), .oe_i(oe), .nwait_i(nwait),
      .force_wait_i(force_wait), .rdata_o(din), .wait_o(wait_l));
   // -------------------------------
   // helpers
   // -------------------------------
   function automatic logic [7:0] rnd();
      lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      return lfsr;
   endfunction : rnd
   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_of_test
   // one request, held until taken; called just after a rising edge
   task automatic req(input bit wr, input logic [15:0] a,
                      input logic [7:0] d, input logic [3:0] w);
      int n;
      req_valid <= 1'b1;
      req_write <= wr;
      req_addr  <= a;
      req_wdata <= d;
      for (n = 0; n < 200; n++) begin
         @(negedge sys_clk);
         if (req_ready === 1'b1) break;
         @(posedge sys_clk);
      end
      @(posedge sys_clk);
      req_valid <= 1'b0;
      nwait     <= w;
      cur_wr    = wr;
      cur_addr  = a;
      cur_wdata = d;
      if (wr && !cur_on) ref_mem[a] = d;
      if (!wr) exp_q.push_back(cur_on ? MEBP_ONCHIP_RD : ref_mem[a]);
      // let an edge pass so a following call never re-raises valid at once
      @(posedge sys_clk);
      if (n == 200) begin
         errors++;
         end_of_test();
      end
   endtask : req
   // take every buffered read byte and compare it
   task automatic drain();
      int n;
      rd_ready <= 1'b1;
      for (n = 0; n < 200 && exp_q.size() > 0; n++) begin
         @(negedge sys_clk);
         if (rd_valid === 1'b1) begin
            chk("read data", exp_q.pop_front(), rd_data);
         end
         @(posedge sys_clk);
      end
      rd_ready <= 1'b0;
      if (n == 200) begin
         errors++;
         end_of_test();
      end
   endtask : drain
   task automatic chip_reset(input logic [1:0] m);
      strap_h    <= m[1];
      strap_l    <= m[0];
      chip_rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("chip reset idle", 16'h1, as_n & rd_n & wr_n & !oe);
      @(posedge sys_clk);
      chip_rst_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("mode", m, mode);
      @(posedge sys_clk);
   endtask : chip_reset
   // -------------------------------
   // pin monitor, settled values at the falling edge
   // -------------------------------
   // forwarded clock is a continuous copy: look once it has settled
   always @(posedge sys_clk) begin
      #1;
      if (mon_en) chk("clock out high", 16'h1, clk_out);
   end
   always @(negedge sys_clk) begin
      #1;
      if (mon_en) begin
         chk("clock out", 16'h0, clk_out);
         chk("strobe overlap", 16'h1, rd_n | wr_n);
         chk("driver enable", !wr_n, oe);
         if (as_n) chk("idle strobes", 16'h1, rd_n & wr_n);
         if (oe) chk("write data", cur_wdata, dout);
         if (cur_on) chk("on-chip strobe", 16'h1, as_n);
         if (!as_n) begin
            chk("address", cur_addr, addr);
            as_cnt++;
            rd_cnt += !rd_n;
            wr_cnt += !wr_n;
         end else if (as_cnt != 0) begin
            chk("strobe length", 3 + nwait, as_cnt);
            chk("read length", cur_wr ? 0 : 2 + nwait, rd_cnt);
            chk("write length", cur_wr ? 2 + nwait : 0, wr_cnt);
            as_cnt = 0;
            rd_cnt = 0;
            wr_cnt = 0;
         end
      end
   end
   // -------------------------------
   // main sequence
   // -------------------------------
   initial begin
      sys_rst = 1'b1;
      chip_rst_n = 1'b0;
      pd_n = 1'b1;
      strap_h = 1'b1;
      strap_l = 1'b1;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = 16'h0000;
      req_wdata = 8'h00;
      rd_ready = 1'b0;
      nwait = 4'h0;
      force_wait = 1'b0;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("reset mode", MEBP_MODE_SINGLE, mode);
      chk("reset pins", 16'h1, as_n & rd_n & wr_n & !oe);
      @(posedge sys_clk);
      sys_rst <= 1'b0;
      mon_en = 1'b1;
      for (i = 3; i >= 1; i--) chip_reset(2'(i));
      $display("test mode straps done");
      for (i = 0; i < 6; i++) begin
         adr[i] = {rnd(), rnd()};
         req(1'b1, adr[i], rnd(), 4'(i % 4));
      end
      // pairs of reads fill the buffer before it is drained
      for (i = 0; i < 6; i += 2) begin
         req(1'b0, adr[i], 8'h00, 4'(i));
         req(1'b0, adr[i+1], 8'h00, 4'h0);
         repeat (10) @(posedge sys_clk);
         @(negedge sys_clk);
         chk("full buffer ready", 16'h0, req_ready);
         @(posedge sys_clk);
         drain();
      end
      $display("test off-chip traffic done");
      chip_reset(MEBP_MODE_EXP_ROM);
      cur_on = 1'b1;
      force_wait <= 1'b1;
      req(1'b0, 16'h1234, 8'h00, 4'h0);
      req(1'b1, 16'h0100, 8'ha5, 4'h0);
      req(1'b0, MEBP_ONCHIP_TOP, 8'h00, 4'h0);
      drain();
      force_wait <= 1'b0;
      cur_on = 1'b0;
      req(1'b1, MEBP_ONCHIP_TOP + 16'h1, rnd(), 4'h2);
      req(1'b0, MEBP_ONCHIP_TOP + 16'h1, 8'h00, 4'h1);
      drain();
      $display("test rom window done");
      pd_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("standby", 16'h1, standby);
      chk("standby ready", 16'h0, req_ready);
      @(posedge sys_clk);
      pd_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("standby left", 16'h0, standby);
      @(posedge sys_clk);
      $display("test standby done");
      chip_reset(MEBP_MODE_SINGLE);
      cur_on = 1'b1;
      req(1'b0, 16'hc000, 8'h00, 4'h0);
      drain();
      // strap pattern 00 is decoded as all on-chip too
      chip_reset(2'h0);
      req(1'b0, 16'h8000, 8'h00, 4'h0);
      drain();
      $display("test single chip done");
      end_of_test();
   end
endmodule : mebp_bus_tb
`default_nettype wire
